// [logic/pcx_crossbar.sv]
// port crossbar top: latches, pin drive, read-back and peripheral inputs
`timescale 1ns/1ns
`include "pcx_regs.svh"

// What this block does
// - first serial port, when enabled, always lands on pins zero and one
// - a peripheral with enables cleared reaches no pin
// - serial ports and SMBus get both their signals together, never transmit alone; three-wire SPI omits NSS
// - unallocated pins are GPIO from byte and bit writable data latches
// - allocated pins follow the peripheral; latch writes leave them alone
// - port and bit reads return the pin level, allocated or not
// - read-modify-write reads return latch contents instead of pins
// - a read right after a write may still return the old pin level
// - all pin drivers stay off until the global crossbar enable is set
// - pins carrying peripheral inputs have their drivers forced off
// - separate enables for counter clock input and both comparator outputs
// - pins fill upward from pin zero in fixed peripheral priority
// - first serial port enable sits at bit two of the first byte
module pcx_crossbar (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire pcx_pkg::pcx_byte_t crossbar_cfg_a_i,
    input wire pcx_pkg::pcx_byte_t crossbar_cfg_b_i,
    input wire pcx_pkg::pcx_byte_t crossbar_cfg_c_i,
    input wire logic spi_three_wire_i,
    input wire logic port_wr_i,
    input wire logic port_rd_i,
    input wire logic port_rmw_i,
    input wire logic [1:0] port_sel_i,
    input wire pcx_pkg::pcx_byte_t port_wdata_i,
    input wire logic bit_wr_i,
    input wire logic bit_rd_i,
    input wire pcx_pkg::pcx_idx_t bit_sel_i,
    input wire logic bit_wdata_i,
    output pcx_pkg::pcx_byte_t port_rdata_o,
    output logic bit_rdata_o,
    input wire pcx_pkg::pcx_sig_vec_t periph_out_i,
    input wire pcx_pkg::pcx_sig_vec_t periph_drive_i,
    output pcx_pkg::pcx_sig_vec_t periph_in_o,
    input wire pcx_pkg::pcx_pin_vec_t pin_i,
    output pcx_pkg::pcx_pin_vec_t pin_o,
    output pcx_pkg::pcx_pin_vec_t pin_oe_n_o,
    output pcx_pkg::pcx_pin_vec_t pin_owned_o,
    output logic crossbar_active_o
);
    import pcx_pkg::*;

    // ------------------------------------------------------------
    // allocation and pin sampling
    // ------------------------------------------------------------
    pcx_sig_vec_t sig_en;
    pcx_idx_t sig_pin [`PCX_SIG_NUM];
    pcx_pin_vec_t owned;
    pcx_idx_t pin_sig [`PCX_PIN_NUM];
    pcx_pin_vec_t pin_lvl;
    logic xbar_en;

    pcx_alloc u_alloc (
        .cfg_a_i(crossbar_cfg_a_i),
        .cfg_b_i(crossbar_cfg_b_i),
        .cfg_c_i(crossbar_cfg_c_i),
        .spi_three_wire_i(spi_three_wire_i),
        .sig_en_o(sig_en),
        .sig_pin_o(sig_pin),
        .pin_owned_o(owned),
        .pin_sig_o(pin_sig)
    );

    pcx_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .pin_i(pin_i),
        .level_o(pin_lvl)
    );

    assign xbar_en = crossbar_cfg_c_i[`PCX_C_XBAR_EN];

    // ------------------------------------------------------------
    // port data latches
    // ------------------------------------------------------------
    pcx_pin_vec_t latch, next_latch;

    // latch takes every write made with the clock enable high, even on allocated pins; only the pin ignores it
    always_comb begin
        next_latch = latch;
        if (clk_en_i) begin
            if (port_wr_i) begin
                next_latch[{port_sel_i, 3'h0} +: 8] = port_wdata_i;
            end
            if (bit_wr_i) begin
                next_latch[bit_sel_i] = bit_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            latch <= `PCX_LATCH_RST;
        end else begin
            latch <= next_latch;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    pcx_pin_vec_t map_out, map_drive;
    pcx_pin_vec_t drv, oe_n, own_q;
    pcx_pin_vec_t next_drv, next_oe_n, next_own;
    logic active, next_active;
    pcx_sig_vec_t in_mask;

    assign in_mask = `PCX_SIG_INPUT_MASK;

    // output mode and pullups live outside; a GPIO pin is offered for drive
    always_comb begin
        map_out = latch;
        map_drive = '1;
        for (int p = 0; p < `PCX_PIN_NUM; p++) begin
            if (owned[p]) begin
                map_out[p] = periph_out_i[pin_sig[p]];
                map_drive[p] = periph_drive_i[pin_sig[p]] & ~in_mask[pin_sig[p]];
            end
        end
        next_drv = drv;
        next_oe_n = oe_n;
        next_own = own_q;
        next_active = active;
        if (clk_en_i) begin
            next_drv = map_out;
            next_oe_n = ~(map_drive & {`PCX_PIN_NUM{xbar_en}});
            next_own = owned;
            next_active = xbar_en;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            drv <= `PCX_LATCH_RST;
            oe_n <= '1;
            own_q <= '0;
            active <= 1'h0;
        end else begin
            drv <= next_drv;
            oe_n <= next_oe_n;
            own_q <= next_own;
            active <= next_active;
        end
    end

    assign pin_o = drv;
    assign pin_oe_n_o = oe_n;
    assign pin_owned_o = own_q;
    assign crossbar_active_o = active;

    // ------------------------------------------------------------
    // read-back
    // ------------------------------------------------------------
    pcx_byte_t rdata, next_rdata;
    logic rbit, next_rbit;

    always_comb begin
        next_rdata = rdata;
        next_rbit = rbit;
        if (clk_en_i && port_rd_i) begin
            next_rdata = port_rmw_i ? latch[{port_sel_i, 3'h0} +: 8]
                                    : pin_lvl[{port_sel_i, 3'h0} +: 8];
        end
        if (clk_en_i && bit_rd_i) begin
            next_rbit = port_rmw_i ? latch[bit_sel_i] : pin_lvl[bit_sel_i];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata <= 8'h00;
            rbit <= 1'h0;
        end else begin
            rdata <= next_rdata;
            rbit <= next_rbit;
        end
    end

    assign port_rdata_o = rdata;
    assign bit_rdata_o = rbit;

    // ------------------------------------------------------------
    // peripheral inputs
    // ------------------------------------------------------------
    pcx_sig_vec_t pin_in, next_pin_in;

    // a signal with no pin idles high so edge-sensitive inputs stay quiet
    always_comb begin
        next_pin_in = pin_in;
        if (clk_en_i) begin
            for (int s = 0; s < `PCX_SIG_NUM; s++) begin
                next_pin_in[s] = sig_en[s] ? pin_lvl[sig_pin[s]] : 1'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_in <= '1;
        end else begin
            pin_in <= next_pin_in;
        end
    end

    assign periph_in_o = pin_in;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_ser0_fixed_pins: assert property (
        clk_en_i && crossbar_cfg_a_i[`PCX_A_SER0_EN]
        |=> own_q[1:0] == 2'h3 && drv[0] == $past(periph_out_i[`PCX_SIG_SER0_TX])
    ) else $error("first serial port not on pins zero and one");

    a_off_no_pin: assert property (
        !crossbar_cfg_b_i[`PCX_B_SYSCLK_EN]
        |-> !(owned[sig_pin[`PCX_SIG_SYSCLK]]
              && pin_sig[sig_pin[`PCX_SIG_SYSCLK]] == 5'(`PCX_SIG_SYSCLK))
    ) else $error("disabled peripheral holds a pin");

    a_serial_pairs: assert property (
        sig_en[`PCX_SIG_SER0_TX] == sig_en[`PCX_SIG_SER0_RX]
        && sig_en[`PCX_SIG_SER1_TX] == sig_en[`PCX_SIG_SER1_RX]
        && sig_en[`PCX_SIG_SMB_SDA] == sig_en[`PCX_SIG_SMB_SCL]
    ) else $error("serial signal allocated without its partner");

    a_gpio_from_latch: assert property (
        clk_en_i |=> (drv & ~own_q) == ($past(latch) & ~own_q)
    ) else $error("gpio pin does not follow its latch");

    // routing and peripheral values held still, so only the latch write could move a pin
    a_owned_ignores_latch: assert property (
        clk_en_i && port_wr_i
        ##1 clk_en_i && $stable(periph_out_i)
            && $stable({crossbar_cfg_a_i, crossbar_cfg_b_i, crossbar_cfg_c_i, spi_three_wire_i})
        |=> (drv & own_q) == ($past(drv) & own_q)
    ) else $error("latch write reached an allocated pin");

    a_read_pin_level: assert property (
        clk_en_i && port_rd_i && !port_rmw_i
        |=> port_rdata_o == $past(pin_lvl[{port_sel_i, 3'h0} +: 8])
    ) else $error("port read did not return pin level");

    a_rmw_reads_latch: assert property (
        clk_en_i && port_rd_i && port_rmw_i
        |=> port_rdata_o == $past(latch[{port_sel_i, 3'h0} +: 8])
    ) else $error("rmw read did not return latch");

    a_drivers_off: assert property (
        (clk_en_i && !xbar_en) [*2] |=> pin_oe_n_o == '1 && !crossbar_active_o
    ) else $error("driver enabled before crossbar enable");

    a_input_undriven: assert property (
        clk_en_i && owned[0] && in_mask[pin_sig[0]] |=> pin_oe_n_o[0]
    ) else $error("peripheral input pin is driven");

    a_ser0_rx_undriven: assert property (
        clk_en_i && crossbar_cfg_a_i[`PCX_A_SER0_EN] |=> pin_oe_n_o[1]
    ) else $error("serial receive pin is driven");

    a_unrouted_input_high: assert property (
        clk_en_i |=> (periph_in_o | $past(sig_en)) == '1
    ) else $error("disabled peripheral sees a pin level");

    a_single_enables: assert property (
        sig_en[`PCX_SIG_ECI] == crossbar_cfg_a_i[`PCX_A_ECI_EN]
        && sig_en[`PCX_SIG_CMPA] == crossbar_cfg_a_i[`PCX_A_CMPA_EN]
        && sig_en[`PCX_SIG_CMPB] == crossbar_cfg_b_i[`PCX_B_CMPB_EN]
    ) else $error("single routing enable mismatch");

    a_dense_alloc: assert property (
        (owned & (owned + 32'h00000001)) == '0 && $countones(owned) == $countones(sig_en)
    ) else $error("pins not filled upward from pin zero");

    a_ser0_bit: assert property (
        sig_en[`PCX_SIG_SER0_TX] == crossbar_cfg_a_i[2]
    ) else $error("serial port enable at wrong bit");

    a_cex_count: assert property (
        sig_en[`PCX_SIG_CAPTURE_COMPARE_OUT_FIRST] == (crossbar_cfg_a_i[5:3] != 3'h0)
        && sig_en[`PCX_SIG_CAPTURE_COMPARE_OUT_FIRST + 5] == (crossbar_cfg_a_i[5:3] >= 3'h6)
    ) else $error("capture/compare count mismatch");

    a_one_signal_pin: assert property (
        !sig_en[`PCX_SIG_CNV2] || (owned[sig_pin[`PCX_SIG_CNV2]]
        && pin_sig[sig_pin[`PCX_SIG_CNV2]] == 5'(`PCX_SIG_CNV2))
    ) else $error("lowest slot shares a pin");

    c_ser0_active: cover property (crossbar_active_o && own_q[0]);
    c_rmw_read: cover property (clk_en_i && port_rd_i && port_rmw_i);
    c_three_wire: cover property (crossbar_cfg_a_i[`PCX_A_SPI_EN] && spi_three_wire_i);
    c_full_load: cover property (owned[`PCX_SIG_NUM-1]);
    c_input_pin: cover property (clk_en_i && owned[0] && in_mask[pin_sig[0]]);
endmodule : pcx_crossbar

// [logic/pcx_regs.svh]
// bit positions, sizes and reset values of the port crossbar
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

`define PCX_PIN_NUM 32
`define PCX_SIG_NUM 30
`define PCX_LATCH_RST 32'hFFFFFFFF
`define PCX_PIN_RST 32'hFFFFFFFF

// first configuration byte
`define PCX_A_SMB_EN 0
`define PCX_A_SPI_EN 1
`define PCX_A_SER0_EN 2
`define PCX_A_CEX_LSB 3
`define PCX_A_CEX_MSB 5
`define PCX_A_ECI_EN 6
`define PCX_A_CMPA_EN 7
// second configuration byte
`define PCX_B_CMPB_EN 0
`define PCX_B_T0_EN 1
`define PCX_B_INT0_EN 2
`define PCX_B_T1_EN 3
`define PCX_B_INT1_EN 4
`define PCX_B_T2_EN 5
`define PCX_B_T2EX_EN 6
`define PCX_B_SYSCLK_EN 7
// third configuration byte
`define PCX_C_CNV0_EN 0
`define PCX_C_T4EX_EN 1
`define PCX_C_SER1_EN 2
`define PCX_C_T4_EN 3
`define PCX_C_XBAR_EN 4
`define PCX_C_CNV2_EN 5

// signal slots in priority order
`define PCX_SIG_SER0_TX 0
`define PCX_SIG_SER0_RX 1
`define PCX_SIG_SPI_SCK 2
`define PCX_SIG_SPI_NSS 5
`define PCX_SIG_SMB_SDA 6
`define PCX_SIG_SMB_SCL 7
`define PCX_SIG_SER1_TX 8
`define PCX_SIG_SER1_RX 9
`define PCX_SIG_CAPTURE_COMPARE_OUT_FIRST 10
`define PCX_SIG_CEX_NUM 6
`define PCX_SIG_ECI 16
`define PCX_SIG_CMPA 17
`define PCX_SIG_CMPB 18
`define PCX_SIG_T0 19
`define PCX_SIG_SYSCLK 27
`define PCX_SIG_CNV0 28
`define PCX_SIG_CNV2 29
// slots that are peripheral inputs only
`define PCX_SIG_INPUT_MASK 30'h35790202

`endif

// [logic/pcx_pkg.sv]
// types shared by the port crossbar modules
`include "pcx_regs.svh"
package pcx_pkg;
    typedef logic [4:0] pcx_idx_t;
    typedef logic [7:0] pcx_byte_t;
    typedef logic [`PCX_SIG_NUM-1:0] pcx_sig_vec_t;
    typedef logic [`PCX_PIN_NUM-1:0] pcx_pin_vec_t;
endpackage : pcx_pkg

// [logic/pcx_pin_sync.sv]
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ns
`include "pcx_regs.svh"
module pcx_pin_sync (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire pcx_pkg::pcx_pin_vec_t pin_i,
    output pcx_pkg::pcx_pin_vec_t level_o
);
    import pcx_pkg::*;

    pcx_pin_vec_t s1, s2, s3, lvl;
    pcx_pin_vec_t next_s1, next_s2, next_s3, next_lvl;
    pcx_pin_vec_t agree;

    // a level counts only once the second and third stages match;
    // the extra latency is why a read right after a write sees the old level
    always_comb begin
        agree = s2 ~^ s3;
        next_s1 = s1;
        next_s2 = s2;
        next_s3 = s3;
        next_lvl = lvl;
        if (clk_en_i) begin
            next_s1 = pin_i;
            next_s2 = s1;
            next_s3 = s2;
            next_lvl = (lvl & ~agree) | (s3 & agree);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s1 <= `PCX_PIN_RST;
            s2 <= `PCX_PIN_RST;
            s3 <= `PCX_PIN_RST;
            lvl <= `PCX_PIN_RST;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            lvl <= next_lvl;
        end
    end

    assign level_o = lvl;
endmodule : pcx_pin_sync

// [logic/pcx_alloc.sv]
// priority pin allocator: signal enables, pin positions, pin owners
`timescale 1ns/1ns
`include "pcx_regs.svh"
module pcx_alloc (
    input wire pcx_pkg::pcx_byte_t cfg_a_i,
    input wire pcx_pkg::pcx_byte_t cfg_b_i,
    input wire pcx_pkg::pcx_byte_t cfg_c_i,
    input wire logic spi_three_wire_i,
    output pcx_pkg::pcx_sig_vec_t sig_en_o,
    output pcx_pkg::pcx_idx_t sig_pin_o [`PCX_SIG_NUM],
    output pcx_pkg::pcx_pin_vec_t pin_owned_o,
    output pcx_pkg::pcx_idx_t pin_sig_o [`PCX_PIN_NUM]
);
    import pcx_pkg::*;

    pcx_sig_vec_t en;
    logic [5:0] pos [`PCX_SIG_NUM+1];
    logic [2:0] cex_cnt;

    // serial groups share one enable, so a pair is never split
    always_comb begin
        cex_cnt = cfg_a_i[`PCX_A_CEX_MSB:`PCX_A_CEX_LSB];
        en = '0;
        en[1:0] = {2{cfg_a_i[`PCX_A_SER0_EN]}};
        en[4:2] = {3{cfg_a_i[`PCX_A_SPI_EN]}};
        en[`PCX_SIG_SPI_NSS] = cfg_a_i[`PCX_A_SPI_EN] & ~spi_three_wire_i;
        en[7:6] = {2{cfg_a_i[`PCX_A_SMB_EN]}};
        en[9:8] = {2{cfg_c_i[`PCX_C_SER1_EN]}};
        for (int k = 0; k < `PCX_SIG_CEX_NUM; k++) begin
            en[`PCX_SIG_CAPTURE_COMPARE_OUT_FIRST + k] = 3'(k) < cex_cnt;
        end
        en[`PCX_SIG_ECI] = cfg_a_i[`PCX_A_ECI_EN];
        en[`PCX_SIG_CMPA] = cfg_a_i[`PCX_A_CMPA_EN];
        en[`PCX_SIG_CMPB] = cfg_b_i[`PCX_B_CMPB_EN];
        en[`PCX_SIG_T0 + 0] = cfg_b_i[`PCX_B_T0_EN];
        en[`PCX_SIG_T0 + 1] = cfg_b_i[`PCX_B_INT0_EN];
        en[`PCX_SIG_T0 + 2] = cfg_b_i[`PCX_B_T1_EN];
        en[`PCX_SIG_T0 + 3] = cfg_b_i[`PCX_B_INT1_EN];
        en[`PCX_SIG_T0 + 4] = cfg_b_i[`PCX_B_T2_EN];
        en[`PCX_SIG_T0 + 5] = cfg_b_i[`PCX_B_T2EX_EN];
        en[`PCX_SIG_T0 + 6] = cfg_c_i[`PCX_C_T4_EN];
        en[`PCX_SIG_T0 + 7] = cfg_c_i[`PCX_C_T4EX_EN];
        en[`PCX_SIG_SYSCLK] = cfg_b_i[`PCX_B_SYSCLK_EN];
        en[`PCX_SIG_CNV0] = cfg_c_i[`PCX_C_CNV0_EN];
        en[`PCX_SIG_CNV2] = cfg_c_i[`PCX_C_CNV2_EN];
    end

    // each enabled slot takes the next free pin, so pins fill upward densely
    assign pos[0] = 6'h00;
    for (genvar s = 0; s < `PCX_SIG_NUM; s++) begin : g_sig
        assign pos[s+1] = pos[s] + {5'h00, en[s]};
        assign sig_pin_o[s] = pos[s][4:0];
    end

    for (genvar p = 0; p < `PCX_PIN_NUM; p++) begin : g_pin
        logic hit;
        pcx_idx_t which;
        always_comb begin
            hit = 1'h0;
            which = 5'h00;
            for (int s = 0; s < `PCX_SIG_NUM; s++) begin
                if (en[s] && pos[s] == 6'(p)) begin
                    hit = 1'h1;
                    which = 5'(s);
                end
            end
        end
        assign pin_owned_o[p] = hit;
        assign pin_sig_o[p] = which;
    end

    assign sig_en_o = en;
endmodule : pcx_alloc

// [verification/pcx_board_model.sv]
// board-side model of the port pins: external drivers and weak pullups
`timescale 1ns/1ns
`include "pcx_regs.svh"
module pcx_board_model (
    input wire pcx_pkg::pcx_pin_vec_t pin_o_i,
    input wire pcx_pkg::pcx_pin_vec_t pin_oe_n_i,
    input wire pcx_pkg::pcx_pin_vec_t ext_en_i,
    input wire pcx_pkg::pcx_pin_vec_t ext_val_i,
    output pcx_pkg::pcx_pin_vec_t pin_lvl_o
);
    import pcx_pkg::*;
    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    // a pin nobody drives floats up through its weak pullup, never keeps a stale value
    always_comb begin
        for (int i = 0; i < `PCX_PIN_NUM; i++) begin
            if (!pin_oe_n_i[i]) begin
                pin_lvl_o[i] = pin_o_i[i];
            end else if (ext_en_i[i]) begin
                pin_lvl_o[i] = ext_val_i[i];
            end else begin
                pin_lvl_o[i] = 1'b1;
            end
        end
    end
endmodule : pcx_board_model

// [verification/pcx_crossbar_tb.sv]
// self-checking testbench of the port crossbar
`timescale 1ns/1ns
module pcx_crossbar_tb;
    import pcx_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en = 1'b1;
    pcx_byte_t cfg_a = 8'h00;
    pcx_byte_t cfg_b = 8'h00;
    pcx_byte_t cfg_c = 8'h00;
    logic three_wire = 1'b0;
    logic port_wr = 1'b0;
    logic port_rd = 1'b0;
    logic rmw = 1'b0;
    logic [1:0] port_sel = 2'h0;
    pcx_byte_t wdata = 8'h00;
    logic bit_wr = 1'b0;
    logic bit_rd = 1'b0;
    pcx_idx_t bit_sel = 5'h00;
    logic bit_wdata = 1'b0;
    pcx_sig_vec_t periph_out = 30'h0;
    pcx_sig_vec_t periph_drive = 30'h3FFFFFFF;
    pcx_pin_vec_t ext_en = 32'h0;
    pcx_pin_vec_t ext_val = 32'h0;
    pcx_byte_t port_rdata;
    logic bit_rdata;
    pcx_sig_vec_t periph_in;
    pcx_pin_vec_t pin_lvl;
    pcx_pin_vec_t pin_o;
    pcx_pin_vec_t pin_oe_n;
    pcx_pin_vec_t pin_owned;
    logic active;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    pcx_byte_t rb;
    logic rbit;
    int n;

    always #2 sys_clk_i = ~sys_clk_i;

    pcx_crossbar pcx_crossbar_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
        .crossbar_cfg_a_i(cfg_a), .crossbar_cfg_b_i(cfg_b), .crossbar_cfg_c_i(cfg_c),
        .spi_three_wire_i(three_wire), .port_wr_i(port_wr), .port_rd_i(port_rd),
        .port_rmw_i(rmw), .port_sel_i(port_sel), .port_wdata_i(wdata),
        .bit_wr_i(bit_wr), .bit_rd_i(bit_rd), .bit_sel_i(bit_sel),
        .bit_wdata_i(bit_wdata), .port_rdata_o(port_rdata), .bit_rdata_o(bit_rdata),
        .periph_out_i(periph_out), .periph_drive_i(periph_drive), .periph_in_o(periph_in),
        .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n), .pin_owned_o(pin_owned),
        .crossbar_active_o(active)
    );

    pcx_board_model pcx_board_model_inst (
        .pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_lvl_o(pin_lvl)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic stop_test();
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic write_port(input logic [1:0] sel, input pcx_byte_t d);
        @(posedge sys_clk_i);
        port_wr <= 1'b1;
        port_sel <= sel;
        wdata <= d;
        @(posedge sys_clk_i);
        port_wr <= 1'b0;
    endtask : write_port

    task automatic write_bit(input pcx_idx_t idx, input logic v);
        @(posedge sys_clk_i);
        bit_wr <= 1'b1;
        bit_sel <= idx;
        bit_wdata <= v;
        @(posedge sys_clk_i);
        bit_wr <= 1'b0;
    endtask : write_bit

    task automatic read_port(input logic [1:0] sel, input logic m, output pcx_byte_t r);
        @(posedge sys_clk_i);
        port_rd <= 1'b1;
        port_sel <= sel;
        rmw <= m;
        @(posedge sys_clk_i);
        port_rd <= 1'b0;
        tick(1);
        r = port_rdata;
    endtask : read_port

    task automatic read_bit(input pcx_idx_t idx, input logic m, output logic r);
        @(posedge sys_clk_i);
        bit_rd <= 1'b1;
        bit_sel <= idx;
        rmw <= m;
        @(posedge sys_clk_i);
        bit_rd <= 1'b0;
        tick(1);
        r = bit_rdata;
    endtask : read_bit

    // routing is written with the global enable low, then enabled
    task automatic set_cfg(input pcx_byte_t a, input pcx_byte_t b, input pcx_byte_t c);
        @(posedge sys_clk_i);
        cfg_a <= a;
        cfg_b <= b;
        cfg_c <= c & 8'hEF;
        repeat (2) @(posedge sys_clk_i);
        cfg_c <= c | 8'h10;
        tick(3);
    endtask : set_cfg

    // pins taken by one enable bit of the three bytes (a=0..7, b=8..15, c=16..23)
    function automatic int pins_for(input int k);
        case (k)
            0, 2, 4, 18: return 2;
            1, 5: return 4;
            20, 22, 23: return 0;
            default: return 1;
        endcase
    endfunction : pins_for

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            stop_test();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        tick(1);
        check(pin_oe_n, 32'hFFFFFFFF);
        check(pin_owned, 32'h0);
        check(active, 1'b0);
        write_port(2'h0, 8'h55);
        write_bit(5'h0A, 1'b0);
        tick(3);
        check(pin_oe_n, 32'hFFFFFFFF);
        set_cfg(8'h00, 8'h00, 8'h10);
        check(active, 1'b1);
        check(pin_oe_n, 32'h0);
        check(pin_o[15:0], 16'hFB55);
        // pin reads lag the drivers through the input synchroniser
        tick(8);
        read_port(2'h0, 1'b0, rb);
        check(rb, 8'h55);
        // a write while the clock enable is low must never reach the latch
        @(posedge sys_clk_i);
        clk_en <= 1'b0;
        write_port(2'h0, 8'h00);
        @(posedge sys_clk_i);
        clk_en <= 1'b1;
        tick(2);
        check(pin_o[7:0], 8'h55);
        // first serial port: tx driven low by the peripheral, rx pulled low by the board
        set_cfg(8'h04, 8'h00, 8'h00);
        write_port(2'h0, 8'hFF);
        ext_en <= 32'h2;
        tick(8);
        check(pin_owned[7:0], 8'h03);
        check(pin_o[0], 1'b0);
        check(pin_oe_n[1:0], 2'b10);
        check(periph_in[1], 1'b0);
        read_port(2'h0, 1'b0, rb);
        check(rb, 8'hFC);
        read_port(2'h0, 1'b1, rb);
        check(rb, 8'hFF);
        read_bit(5'h01, 1'b0, rbit);
        check(rbit, 1'b0);
        read_bit(5'h01, 1'b1, rbit);
        check(rbit, 1'b1);
        @(posedge sys_clk_i);
        ext_en <= 32'h0;
        // ascending allocation: tx, rx, clock input, comparator a, comparator b
        periph_out <= 30'h00020000;
        set_cfg(8'hC4, 8'h01, 8'h00);
        check(pin_owned[7:0], 8'h1F);
        check(pin_oe_n[2], 1'b1);
        check(pin_o[4:3], 2'b01);
        @(posedge sys_clk_i);
        periph_out <= 30'h0;
        for (int i = 0; i < 8; i++) begin
            set_cfg(8'h04 | 8'(i << 3), 8'h00, 8'h00);
            n = (i > 6) ? 8 : i + 2;
            check(pin_owned, (32'h1 << n) - 32'h1);
        end
        for (int k = 0; k < 24; k++) begin
            if (k != 20 && k != 22 && k != 23) begin
                set_cfg(8'(24'h1 << k), 8'(24'h1 << k >> 8), 8'(24'h1 << k >> 16));
                check(pin_owned, (32'h1 << pins_for(k)) - 32'h1);
                if (pins_for(k) == 1) begin
                    check(pin_oe_n[0], 1'(24'h235E40 >> k));
                end
            end
        end
        @(posedge sys_clk_i);
        three_wire <= 1'b1;
        set_cfg(8'h02, 8'h00, 8'h00);
        check(pin_owned, 32'h7);
        set_cfg(8'h00, 8'h00, 8'h00);
        tick(8);
        check(pin_owned, 32'h0);
        check(periph_in, 30'h3FFFFFFF);
        stop_test();
    end
endmodule : pcx_crossbar_tb
